// file: verilog/msl_sync_logic.sv
// multichip sync logic: pulse and pn code sync, error flags, interrupt pin
`timescale 1ns/10ps
`include "msl_params.svh"

module msl_sync_logic #(
	parameter logic [31:0] PN_CODE = `MSL_PN_CODE
) (
	// clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        clkEn,
	// register port
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	input  wire logic [4:0]  regAddr,
	input  wire logic [31:0] regWrData,
	output logic      [31:0] regRdData,
	// sync input and its margin monitor
	input  wire logic        syncIn,
	input  wire logic        marginValid,
	input  wire logic [3:0]  setupMargin,
	input  wire logic [3:0]  holdMargin,
	output logic      [4:0]  syncInDelay,
	output logic             syncCheckMode,
	// word clock side
	input  wire logic        wordStrobe,
	input  wire logic        transmitGate,
	input  wire logic        gateInvert,
	input  wire logic        dataTimingErr,
	// clock machine and nco
	output logic      [4:0]  clkState,
	output logic             initPulse,
	output logic             ncoPhaseReset,
	// coded sync output
	output logic             syncOut,
	output logic             syncOutEn,
	output logic      [4:0]  syncOutDelay,
	output logic             syncOutHalfShift,
	// status and interrupt pin
	output logic             syncLocked,
	output logic             irqOut,
	output logic             irqOe
);

	// ==========================================
	// state
	msl_pkg::msl_state_s s_r;
	msl_pkg::msl_state_s s_nxt;

	logic        pulseMode;
	logic        pnMode;
	logic        riseSeen;
	logic        codeValid;
	logic        gateNow;
	logic        setupBad;
	logic        holdBad;
	logic [5:0]  matchCnt;
	logic [5:0]  matchNeed;
	logic [31:0] matchVec;

	// ==========================================
	// derived constants
	// last count of the lock window; one more cycle with no
	// valid code drops lock
	localparam logic [5:0] LOCK_LAST = `MSL_LOCK_WINDOW - 6'h01;

	// ==========================================
	// correlator match bits
	// one agreement bit per chip; the adder below counts them
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_match
			assign matchVec[gi] = ~(s_r.rxShift[gi] ^ PN_CODE[gi]);
		end
	endgenerate

	// ==========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.initPulse = 1'b0;
		s_nxt.ncoReset = 1'b0;

		// modes decode from stored bits only, so a half-written setup
		// stays idle until the second register lands
		pulseMode = s_r.portCfg[`MSL_PORT_IN_EN]
			& s_r.modeCtl[`MSL_MODE_PULSE_EN]
			& ~s_r.modeCtl[`MSL_MODE_PN_EN];
		pnMode = s_r.portCfg[`MSL_PORT_IN_EN]
			& s_r.modeCtl[`MSL_MODE_PN_EN]
			& s_r.modeCtl[`MSL_MODE_SEL]
			& ~s_r.modeCtl[`MSL_MODE_PULSE_EN];

		// register writes first, so hardware sets below win over clears
		if (regWrEn) begin
			case (regAddr)
				`MSL_ADDR_MODE: begin
					s_nxt.modeCtl = regWrData;
				end
				`MSL_ADDR_PORT: begin
					s_nxt.portCfg = regWrData;
				end
				`MSL_ADDR_IRQ: begin
					s_nxt.syncIrqEn = regWrData[`MSL_IRQ_SYNC_EN];
					s_nxt.dataIrqEn = regWrData[`MSL_IRQ_DATA_EN];
					// error flags clear on a one; a zero leaves them alone
					if (regWrData[`MSL_IRQ_DATA_ERR]) begin
						s_nxt.dataErr = 1'b0;
					end
					if (regWrData[`MSL_IRQ_SYNC_ERR]) begin
						s_nxt.syncErr = 1'b0;
					end
					// lock-lost clears when the stored clear bit falls, so
					// a lone write of one never drops the flag
					s_nxt.clearLock = regWrData[`MSL_IRQ_CLR_LOCK];
					if (s_r.clearLock && !regWrData[`MSL_IRQ_CLR_LOCK]) begin
						s_nxt.lockLost = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// sync input capture on the sample clock
		s_nxt.syncSample = syncIn;
		s_nxt.syncPrev = s_r.syncSample;
		riseSeen = pulseMode & s_r.syncSample & ~s_r.syncPrev;

		// correlator over the last 32 samples
		s_nxt.rxShift = {s_r.rxShift[30:0], s_r.syncSample};
		// every window bit that agrees with the code counts once
		matchCnt = 6'h00;
		for (int i = 0; i < 32; i++) begin
			matchCnt = matchCnt + {5'h00, matchVec[i]};
		end
		// threshold raises the required agreement from half the code by up to 15 chips
		matchNeed = `MSL_THR_BASE
			+ {2'h0, s_r.portCfg[`MSL_PORT_THR_HI:`MSL_PORT_THR_LO+1]};
		// the reset threshold asks for 24 of 32 chips, so a few bad chips pass
		codeValid = pnMode & (matchCnt >= matchNeed);

		// 32-state clock generation machine
		// wraps at 32 on its own; a load only moves the phase
		s_nxt.clkState = s_r.clkState + 5'h01;
		if (riseSeen || codeValid) begin
			s_nxt.initPulse = 1'b1;
			s_nxt.clkState = {1'b0,
				s_r.portCfg[`MSL_PORT_PHASE_HI:`MSL_PORT_PHASE_LO]};
		end

		// slaves align their nco from the decoded code
		if (codeValid) begin
			s_nxt.ncoReset = 1'b1;
		end

		// master code emission
		// the chip index wraps at 32, so the code repeats with no gap
		s_nxt.syncOutEn = pnMode & s_r.portCfg[`MSL_PORT_OUT_EN];
		if (s_nxt.syncOutEn) begin
			s_nxt.syncOut = PN_CODE[5'd31 - s_r.chipIdx];
			s_nxt.chipIdx = s_r.chipIdx + 5'h01;
		end else begin
			s_nxt.syncOut = 1'b0;
			s_nxt.chipIdx = 5'h00;
		end

		// lock tracking: a missing code for a whole period drops lock
		// leaving pn mode is deliberate, so it is not reported as a loss
		if (!pnMode) begin
			s_nxt.locked = 1'b0;
			s_nxt.sinceValid = 6'h00;
		end else if (codeValid) begin
			s_nxt.locked = 1'b1;
			s_nxt.sinceValid = 6'h00;
		end else if (s_r.locked) begin
			s_nxt.sinceValid = s_r.sinceValid + 6'h01;
			if (s_r.sinceValid >= LOCK_LAST) begin
				s_nxt.locked = 1'b0;
				s_nxt.lockLost = 1'b1;
			end
		end

		// transmit gate on the word strobe; in pulse mode a falling active level resets
		// the history moves only on word strobes, so the edge is judged
		// between two word samples, never between sample clocks
		gateNow = transmitGate ^ gateInvert;
		if (wordStrobe) begin
			s_nxt.gatePrev = gateNow;
			if (pulseMode && s_r.gatePrev && !gateNow) begin
				s_nxt.ncoReset = 1'b1;
			end
		end

		// margin check: flags even when the sample itself was right
		setupBad = setupMargin
			< s_r.portCfg[`MSL_PORT_MARGIN_HI:`MSL_PORT_MARGIN_LO];
		holdBad = holdMargin
			< s_r.portCfg[`MSL_PORT_MARGIN_HI:`MSL_PORT_MARGIN_LO];
		// both margins short is reported as a setup fault
		if (marginValid && s_r.portCfg[`MSL_PORT_IN_EN]
				&& (setupBad || holdBad)) begin
			s_nxt.syncErr = 1'b1;
			s_nxt.syncErrType = holdBad & ~setupBad;
		end
		if (dataTimingErr) begin
			s_nxt.dataErr = 1'b1;
		end

		// open-drain pin: enable pulls low, released when nothing unmasked
		// built from the next flags so the pin moves in the same cycle
		// as the flag that causes it
		s_nxt.irqOut = 1'b0;
		s_nxt.irqOe = (s_nxt.syncErr & s_nxt.syncIrqEn)
			| (s_nxt.dataErr & s_nxt.dataIrqEn);

		// register reads, one cycle latency, unmapped reads zero
		// the read word holds between reads for a slow reader
		if (regRdEn) begin
			case (regAddr)
				`MSL_ADDR_MODE: begin
					s_nxt.rdData = s_r.modeCtl;
				end
				`MSL_ADDR_PORT: begin
					s_nxt.rdData = s_r.portCfg;
				end
				`MSL_ADDR_IRQ: begin
					s_nxt.rdData = 32'h00000000;
					s_nxt.rdData[`MSL_IRQ_SYNC_EN] = s_r.syncIrqEn;
					s_nxt.rdData[`MSL_IRQ_DATA_EN] = s_r.dataIrqEn;
					s_nxt.rdData[`MSL_IRQ_ERR_TYPE] = s_r.syncErrType;
					s_nxt.rdData[`MSL_IRQ_DATA_ERR] = s_r.dataErr;
					s_nxt.rdData[`MSL_IRQ_SYNC_ERR] = s_r.syncErr;
					s_nxt.rdData[`MSL_IRQ_LOCKED] = s_r.locked;
					s_nxt.rdData[`MSL_IRQ_LOCK_LOST] = s_r.lockLost;
					s_nxt.rdData[`MSL_IRQ_CLR_LOCK] = s_r.clearLock;
				end
				default: begin
					s_nxt.rdData = 32'h00000000;
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk) begin
		// reset ahead of the enable, so a frozen block still comes up clean
		if (srst) begin
			s_r <= '0;
			s_r.modeCtl <= `MSL_MODE_RESET;
			s_r.portCfg <= `MSL_PORT_RESET;
		end else if (clkEn) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// outputs, all taken from state flops
	assign regRdData        = s_r.rdData;
	assign syncInDelay      = s_r.portCfg[`MSL_PORT_IN_DLY_HI:
		`MSL_PORT_IN_DLY_LO];
	assign syncCheckMode    = s_r.portCfg[`MSL_PORT_CHK_MODE];
	assign clkState         = s_r.clkState;
	assign initPulse        = s_r.initPulse;
	assign ncoPhaseReset    = s_r.ncoReset;
	assign syncOut          = s_r.syncOut;
	assign syncOutEn        = s_r.syncOutEn;
	// sub-cycle delays are handed to the output pad delay line
	assign syncOutDelay     = s_r.portCfg[`MSL_PORT_OUT_DLY_HI:
		`MSL_PORT_OUT_DLY_LO];
	assign syncOutHalfShift = s_r.portCfg[`MSL_PORT_OUT_POL];
	assign syncLocked       = s_r.locked;
	assign irqOut           = s_r.irqOut;
	assign irqOe            = s_r.irqOe;

endmodule

// file: common/msl_params.svh
// constants for the multichip sync logic: offsets, fields, resets, counts
`ifndef MSL_PARAMS_SVH
`define MSL_PARAMS_SVH

// ==========================================
// register word addresses
`define MSL_ADDR_MODE       5'h01
`define MSL_ADDR_PORT       5'h03
`define MSL_ADDR_IRQ        5'h09

// ==========================================
// sync_mode_control fields
`define MSL_MODE_PN_EN      13
`define MSL_MODE_SEL        12
`define MSL_MODE_PULSE_EN   11

// ==========================================
// sync_port_config fields
`define MSL_PORT_THR_HI     31
`define MSL_PORT_THR_LO     27
`define MSL_PORT_IN_EN      26
`define MSL_PORT_OUT_EN     25
`define MSL_PORT_IN_DLY_HI  23
`define MSL_PORT_IN_DLY_LO  19
`define MSL_PORT_CHK_MODE   18
`define MSL_PORT_OUT_DLY_HI 15
`define MSL_PORT_OUT_DLY_LO 11
`define MSL_PORT_SET_HIGH   10
`define MSL_PORT_OUT_POL    9
`define MSL_PORT_PHASE_HI   7
`define MSL_PORT_PHASE_LO   4
`define MSL_PORT_MARGIN_HI  3
`define MSL_PORT_MARGIN_LO  0

// ==========================================
// interrupt_and_lock_status fields
`define MSL_IRQ_SYNC_EN     0
`define MSL_IRQ_DATA_EN     1
`define MSL_IRQ_ERR_TYPE    4
`define MSL_IRQ_DATA_ERR    5
`define MSL_IRQ_SYNC_ERR    6
`define MSL_IRQ_LOCKED      10
`define MSL_IRQ_LOCK_LOST   11
`define MSL_IRQ_CLR_LOCK    12

// ==========================================
// reset values and counts
`define MSL_MODE_RESET      32'h00000000
`define MSL_PORT_RESET      32'h80000000
`define MSL_THR_BASE        6'h10
`define MSL_LOCK_WINDOW     6'h20
`define MSL_DELAY_STEP_PS   80
`define MSL_PN_CODE         32'h0EED2C9B

`endif

// file: common/msl_pkg.sv
// types of the multichip sync logic
package msl_pkg;

	// ==========================================
	// whole state of the sync block
	typedef struct packed {
		logic [31:0] modeCtl;
		logic [31:0] portCfg;
		logic        syncIrqEn;
		logic        dataIrqEn;
		logic        syncErrType;
		logic        dataErr;
		logic        syncErr;
		logic        locked;
		logic        lockLost;
		logic        clearLock;
		logic        syncSample;
		logic        syncPrev;
		logic        gatePrev;
		logic [4:0]  clkState;
		logic [4:0]  chipIdx;
		logic [31:0] rxShift;
		logic [5:0]  sinceValid;
		logic        initPulse;
		logic        ncoReset;
		logic        syncOut;
		logic        syncOutEn;
		logic        irqOut;
		logic        irqOe;
		logic [31:0] rdData;
	} msl_state_s;

endpackage

// file: dv/msl_sync_src.sv
// sync source: clock distributor pulses or master stream loopback
`timescale 1ns/10ps
module msl_sync_src (
	// clock, reset, controls
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic fire,
	input  wire logic loopOn,
	// coded stream in, line to the sync input
	input  wire logic codeIn,
	output logic      syncLine
);
	logic [4:0] cnt;
	// ==========================================
	// burst of two pulses, one every 16 sample clocks
	always_ff @(posedge sys_clk)
		if (srst)
			cnt <= 5'h00;
		else if (fire || cnt != 5'h00)
			cnt <= cnt + 5'h01;
	// loop stands for the master output wired to every sync input
	assign syncLine = loopOn ? codeIn : cnt[3];
endmodule

// file: dv/msl_sync_logic_sva.sv
// assertions on the ports of the multichip sync logic
`timescale 1ns/10ps
module msl_sync_logic_sva (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        srst,
	input wire logic        clkEn,
	// stimulus side
	input wire logic        regWrEn,
	input wire logic        regRdEn,
	input wire logic        marginValid,
	input wire logic        dataTimingErr,
	// design outputs
	input wire logic [31:0] regRdData,
	input wire logic [4:0]  clkState,
	input wire logic        initPulse,
	input wire logic        ncoPhaseReset,
	input wire logic        syncOut,
	input wire logic        syncOutEn,
	input wire logic        syncLocked,
	input wire logic        irqOut,
	input wire logic        irqOe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// ==========================================
	// pulses and clock machine
	property p_init_one; initPulse && clkEn |=> !initPulse; endproperty
	a_init_one: assert property (p_init_one)
		else $error("init pulse wider than one cycle");
	property p_clk_run;
		$past(clkEn) && !$past(srst) && !initPulse
			|-> clkState == $past(clkState) + 5'h01;
	endproperty
	a_clk_run: assert property (p_clk_run)
		else $error("clock machine skipped a state");
	property p_nco_one;
		ncoPhaseReset && clkEn |=> !ncoPhaseReset;
	endproperty
	a_nco_one: assert property (p_nco_one)
		else $error("phase reset wider than one cycle");
	property p_lock_pulse;
		$rose(syncLocked) |-> initPulse && ncoPhaseReset;
	endproperty
	a_lock_pulse: assert property (p_lock_pulse)
		else $error("lock without sync pulse");
	property p_out_quiet; !syncOutEn |-> !syncOut; endproperty
	a_out_quiet: assert property (p_out_quiet)
		else $error("coded output while not master");
	// ==========================================
	// interrupt pin and read port
	property p_irq_drain; irqOut == 1'b0; endproperty
	a_irq_drain: assert property (p_irq_drain)
		else $error("interrupt pin driven high");
	property p_irq_latch; irqOe && !regWrEn |=> irqOe; endproperty
	a_irq_latch: assert property (p_irq_latch)
		else $error("interrupt dropped without a write");
	property p_irq_cause;
		$rose(irqOe) |-> $past(dataTimingErr || marginValid || regWrEn);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt raised without a cause");
	property p_rd_hold; !$past(regRdEn) |-> $stable(regRdData); endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a read");
endmodule

bind msl_sync_logic msl_sync_logic_sva chk (.sys_clk, .srst, .clkEn, .regWrEn,
	.regRdEn, .marginValid, .dataTimingErr, .regRdData, .clkState, .initPulse,
	.ncoPhaseReset, .syncOut, .syncOutEn, .syncLocked, .irqOut, .irqOe);

// file: dv/msl_tb.sv
// self-checking testbench of the multichip sync logic
`timescale 1ns/10ps
`include "msl_params.svh"
module testbench;
	logic        sys_clk = 1'b0, srst = 1'b1, clkEn = 1'b1;
	logic        regWrEn = 1'b0, regRdEn = 1'b0, syncIn, marginValid = 1'b0;
	logic [4:0]  regAddr = 5'h00, syncInDelay, clkState, syncOutDelay;
	logic [31:0] regWrData = 32'h00000000, regRdData;
	logic [3:0]  setupMargin = 4'h0, holdMargin = 4'h0;
	logic        wordStrobe = 1'b0, transmitGate = 1'b1, gateInvert = 1'b0;
	logic        dataTimingErr = 1'b0, syncCheckMode, initPulse, ncoPhaseReset;
	logic        syncOut, syncOutEn, syncOutHalfShift, syncLocked, irqOut, irqOe;
	logic        fire = 1'b0, loopOn = 1'b0;
	int          bad_count = 0, compares = 0;

	msl_sync_logic uut (.sys_clk, .srst, .clkEn, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData, .syncIn, .marginValid, .setupMargin, .holdMargin,
		.syncInDelay, .syncCheckMode, .wordStrobe, .transmitGate, .gateInvert,
		.dataTimingErr, .clkState, .initPulse, .ncoPhaseReset, .syncOut,
		.syncOutEn, .syncOutDelay, .syncOutHalfShift, .syncLocked, .irqOut, .irqOe);
	msl_sync_src far (.sys_clk, .srst, .fire, .loopOn, .codeIn(syncOut),
		.syncLine(syncIn));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ==========================================
	// shared tasks
	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1;
		chk(regRdData & m, e);
	endtask
	task automatic margin(input logic [3:0] s, input logic [3:0] h);
		@(posedge sys_clk);
		marginValid <= 1'b1;
		setupMargin <= s;
		holdMargin <= h;
		@(posedge sys_clk);
		marginValid <= 1'b0;
		#1;
	endtask
	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		rd(`MSL_ADDR_MODE, 32'hFFFFFFFF, 32'h00000000);
		rd(`MSL_ADDR_PORT, 32'hFFFFFFFF, 32'h80000000);
		rd(`MSL_ADDR_IRQ, 32'hFFFFFFFF, 32'h00000000);
		wr(5'h05, 32'hFFFFFFFF);
		rd(5'h05, 32'hFFFFFFFF, 32'h00000000);
	endtask
	task automatic t_pulse;
		int n;
		wr(`MSL_ADDR_MODE, 32'h00000800);
		wr(`MSL_ADDR_PORT, 32'h84000050);
		@(posedge sys_clk);
		fire <= 1'b1;
		@(posedge sys_clk);
		fire <= 1'b0;
		for (n = 0; n < 40 && initPulse !== 1'b1; n++) tick;
		chk(clkState, 32'h5);
		tick;
		chk(initPulse, 32'h0);
		chk(clkState, 32'h6);
		n = 1;
		do begin
			tick;
			n++;
		end while (initPulse !== 1'b1 && n < 40);
		chk(n, 16);
		chk(clkState, 32'h5);
		@(posedge sys_clk);
		clkEn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		clkEn <= 1'b1;
		#1;
		chk(clkState, 32'h6);
		tick;
		chk(clkState, 32'h7);
	endtask
	task automatic t_gate(input logic inv);
		int n;
		gateInvert <= inv;
		for (n = 0; n < 2; n++) begin
			@(posedge sys_clk);
			wordStrobe <= 1'b1;
			transmitGate <= inv ^ (n == 0);
			@(posedge sys_clk);
			wordStrobe <= 1'b0;
		end
		#1;
		for (n = 0; n < 4 && ncoPhaseReset !== 1'b1; n++) tick;
		chk(ncoPhaseReset, 32'h1);
		transmitGate <= ~inv;
	endtask
	task automatic t_margin;
		wr(`MSL_ADDR_PORT, 32'h84000004);
		wr(`MSL_ADDR_IRQ, 32'h00000001);
		margin(4'h2, 4'h9);
		chk(irqOe, 32'h1);
		chk(irqOut, 32'h0);
		rd(`MSL_ADDR_IRQ, 32'h00000051, 32'h00000041);
		wr(`MSL_ADDR_IRQ, 32'h00000041);
		chk(irqOe, 32'h0);
		rd(`MSL_ADDR_IRQ, 32'h00000040, 32'h00000000);
		margin(4'h9, 4'h1);
		rd(`MSL_ADDR_IRQ, 32'h00000050, 32'h00000050);
		wr(`MSL_ADDR_IRQ, 32'h00000000);
		chk(irqOe, 32'h0);
		rd(`MSL_ADDR_IRQ, 32'h00000040, 32'h00000040);
		wr(`MSL_ADDR_IRQ, 32'h00000042);
		@(posedge sys_clk);
		dataTimingErr <= 1'b1;
		@(posedge sys_clk);
		dataTimingErr <= 1'b0;
		tick;
		chk(irqOe, 32'h1);
		rd(`MSL_ADDR_IRQ, 32'h00000060, 32'h00000020);
	endtask
	task automatic t_pn;
		int n;
		logic [31:0] w;
		wr(`MSL_ADDR_IRQ, 32'h00000020);
		wr(`MSL_ADDR_MODE, 32'h00003000);
		wr(`MSL_ADDR_PORT, 32'h865CAE00);
		tick;
		chk(syncInDelay, 32'h0B);
		chk(syncCheckMode, 32'h1);
		chk(syncOutDelay, 32'h15);
		chk(syncOutHalfShift, 32'h1);
		chk(syncOutEn, 32'h1);
		w = 32'h00000000;
		for (n = 0; n < 32; n++) begin
			w = {w[30:0], syncOut};
			tick;
		end
		chk(w, `MSL_PN_CODE);
		loopOn <= 1'b1;
		for (n = 0; n < 200 && syncLocked !== 1'b1; n++) tick;
		rd(`MSL_ADDR_IRQ, 32'h00001C00, 32'h00000400);
		loopOn <= 1'b0;
		for (n = 0; n < 100 && syncLocked !== 1'b0; n++) tick;
		rd(`MSL_ADDR_IRQ, 32'h00001C00, 32'h00000800);
		wr(`MSL_ADDR_IRQ, 32'h00001000);
		wr(`MSL_ADDR_IRQ, 32'h00000000);
		rd(`MSL_ADDR_IRQ, 32'h00001C00, 32'h00000000);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset;
		t_pulse;
		t_gate(1'b0);
		t_gate(1'b1);
		t_margin;
		t_pn;
		final_report;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		final_report;
	end
endmodule
